// >>> logic/twi_path_pkg.sv
// Package: register map, field layout and states of the two-wire data path
package twi_path_pkg;

	// Register byte addresses on APB
	localparam logic [7:0] ADDR_WORD_COUNT = 8'h00;
	localparam logic [7:0] ADDR_RECEIVE    = 8'h04;
	localparam logic [7:0] ADDR_TARGET     = 8'h08;
	localparam logic [7:0] ADDR_TRANSMIT   = 8'h0C;
	localparam logic [7:0] ADDR_MODE       = 8'h10;
	localparam logic [7:0] ADDR_STATUS     = 8'h14;

	// Mode register field positions
	localparam int MODE_FORCE_NO_ACK = 15;
	localparam int MODE_FREE_RUN     = 14;
	localparam int MODE_START        = 13;
	localparam int MODE_STOP         = 11;
	localparam int MODE_MASTER       = 10;
	localparam int MODE_TRANSMITTER  = 9;
	localparam int MODE_WIDE_ADDR    = 8;
	localparam int MODE_REPEAT       = 7;
	localparam int MODE_LOOPBACK     = 6;
	localparam int MODE_RUN          = 5;
	localparam int MODE_START_BYTE   = 4;
	localparam int MODE_FREE_FORMAT  = 3;

	// Writable mode bits; bit 12 and 31-16 stay zero
	localparam logic [15:0] MODE_WRITE_MASK  = 16'hEFFF;
	localparam logic [15:0] MODE_RESET       = 16'h0000;
	localparam logic [15:0] COUNT_RESET      = 16'h0000;
	localparam logic [9:0]  TARGET_RESET     = 10'h000;
	localparam logic [16:0] COUNT_FULL       = 17'h10000;
	localparam logic [9:0]  NARROW_ADDR_MASK = 10'h07F;
	localparam logic [7:0]  DATA_RESET       = 8'h00;

	// Link bit timing in pclk ticks: eight ticks per bit
	localparam logic [2:0]  TICK_LAST        = 3'h7; // Last tick of a bit
	localparam logic [2:0]  TICK_RISE        = 3'h4; // Clock released here
	localparam logic [2:0]  TICK_FALL        = 3'h6; // Start edge on data

	// Bus phases of the link engine
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_ADDR  = 3'b010,
		ST_DATA  = 3'b011,
		ST_ACK   = 3'b100,
		ST_STOP  = 3'b101
	} phase_t;

	// Link pins (open drain, two signals each)
	typedef struct packed {
		logic scl_o;
		logic scl_oe;
		logic sda_o;
		logic sda_oe;
	} pins_out_t;

endpackage : twi_path_pkg

// >>> logic/twi_shifter.sv
// Shift register pair: hidden receive and transmit shifters
`timescale 1ns/10ps
`default_nettype none
module twi_shifter
	import twi_path_pkg::*;
(
	input  wire logic       pclk,        // Module clock
	input  wire logic       presetn,     // Async reset, low
	input  wire logic       load,        // Copy buffer into transmit shifter
	input  wire logic [7:0] load_data,   // Transmit word
	input  wire logic       shift,       // One bit step
	input  wire logic       sda_in,      // Sampled data line
	output logic            tx_bit,      // Current transmit bit
	output logic      [7:0] rx_word      // Receive shifter contents
);
	// Shifters stay private to this block; software never sees them
	typedef struct packed {
		logic [7:0] transmit_shifter; // Serialised out MSB first
		logic [7:0] receive_shifter;  // Filled LSB in, right aligned
	} sh_t;

	sh_t s_reg;  // State
	sh_t s_next; // Next state

	// Load has priority so a fresh word never mixes with the old one
	always_comb begin
		s_next = s_reg;
		if (load) begin
			s_next.transmit_shifter = load_data;
		end else if (shift) begin
			s_next.transmit_shifter = {s_reg.transmit_shifter[6:0], 1'b0};
			s_next.receive_shifter  = {s_reg.receive_shifter[6:0], sda_in};
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tx_bit  = s_reg.transmit_shifter[7];
	assign rx_word = s_reg.receive_shifter;
endmodule // twi_shifter
`default_nettype wire

// >>> logic/twi_data_path.sv
// Count, target address and data buffer path of a two-wire bus master
// Function
// - Count used only master-transmit, repeat off; the counter also sets ack and stop in master-receive, repeat on or off
// - Internal counter copy, decrements, register unchanged
// - Stop requested: stop when counter hits zero
// - Count zero loads 65536, else value
// - Count in 15-0, upper bits read zero
// - Received word right aligned in field
// - Word length from mode bit-count field
// - Hidden receive shifter copied to buffer
// - Fixed format uses target address register
// - Address zero is general call
// - Narrow mode sends address bits 6-0
// - Wide mode sends bits 9-0, upper zero
// - Transmit buffer copied into hidden shifter
// - Mode register fields, all reset zero
// - Receiver acks until counter zero, then nack
// - Stop request clears after stop
// - Master bit clears after stop
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module twi_data_path
	import twi_path_pkg::*;
(
	input  wire logic        pclk,      // Module clock, 10 MHz
	input  wire logic        presetn,   // Async reset, low
	input  wire logic        psel,      // APB select
	input  wire logic        penable,   // APB access phase
	input  wire logic        pwrite,    // APB direction
	input  wire logic [7:0]  paddr,     // APB byte address
	input  wire logic [31:0] pwdata,    // APB write data
	output logic      [31:0] prdata,    // APB read data
	output logic             pready,    // APB ready
	output logic             pslverr,   // APB error, unmapped
	input  wire logic        scl_i,     // Clock line level
	input  wire logic        sda_i,     // Data line level
	output logic             scl_o,     // Clock line drive value
	output logic             scl_oe,    // Clock line enable
	output logic             sda_o,     // Data line drive value
	output logic             sda_oe     // Data line enable
);
	// Whole state of the block
	typedef struct packed {
		logic [31:0] rdata;             // APB read data
		logic        ready;             // APB ready
		logic        err;               // APB error
		logic [15:0] word_count_field;  // Software count
		logic [9:0]  target_address_field; // Target address
		logic [7:0]  transmit_buffer;   // Transmit buffer
		logic        tx_full;           // Buffer holds unsent word
		logic [7:0]  receive_buffer;    // Receive buffer
		logic        rx_full;           // Unread received word
		logic [15:0] mode;              // Mode register
		logic [16:0] counter;           // Internal word counter
		phase_t      phase;             // Link phase
		logic [3:0]  bits;              // Bits left in phase
		logic [10:0] addr_sr;           // Address bits to send
		logic        first_addr;        // Ack slot follows the address
		logic [2:0]  tick;              // Tick within one bit
		logic        restart;           // Start follows a finished word
		pins_out_t   pins;              // Line drive
		logic        sda_s1;            // Sync stage 1
		logic        sda_s2;            // Sync stage 2
		logic        scl_s1;            // Sync stage 1
		logic        scl_s2;            // Sync stage 2
	} st_t;

	st_t s_reg;  // State
	st_t s_next; // Next state

	logic       sh_load;  // Shifter load strobe
	logic       sh_shift; // Shifter bit step
	logic       tx_bit;   // Transmit bit out
	logic [7:0] rx_word;  // Receive shifter contents

	// Word length 1..8; code 0 means eight bits
	function automatic logic [3:0] word_len(input logic [2:0] code);
		word_len = (code == 3'b000) ? 4'h8 : {1'b0, code};
	endfunction

	// Counter start value: zero means 65536
	function automatic logic [16:0] count_start(input logic [15:0] c);
		count_start = (c == 16'h0000) ? COUNT_FULL : {1'b0, c};
	endfunction

	twi_shifter u_shift (
		.pclk      (pclk),
		.presetn   (presetn),
		.load      (sh_load),
		.load_data (s_reg.transmit_buffer),
		.shift     (sh_shift),
		.sda_in    (s_reg.sda_s2),
		.tx_bit    (tx_bit),
		.rx_word   (rx_word)
	);

	logic        wr;        // APB write accepted
	logic        rd;        // APB read accepted
	logic        counting;  // Count governs this transfer
	logic [15:0] wmode;     // Masked mode write
	logic [3:0]  len;       // Current word length
	logic        step_end;  // Last tick of a bit
	logic        clk_low;   // Clock held low this tick

	// One combinational step of the whole block
	always_comb begin
		s_next   = s_reg;
		sh_load  = 1'b0;
		sh_shift = 1'b0;
		wr       = psel && penable && pwrite;
		rd       = psel && penable && !pwrite;
		wmode    = pwdata[15:0] & MODE_WRITE_MASK;
		len      = word_len(s_reg.mode[2:0]);
		step_end = (s_reg.tick == TICK_LAST);
		clk_low  = (s_reg.tick < TICK_RISE);
		// Count only for master transmitter, repeat off
		counting = s_reg.mode[MODE_MASTER] && s_reg.mode[MODE_TRANSMITTER]
			&& !s_reg.mode[MODE_REPEAT];

		// Pin synchronisers, two stages before use
		s_next.sda_s1 = sda_i;
		s_next.sda_s2 = s_reg.sda_s1;
		s_next.scl_s1 = scl_i;
		s_next.scl_s2 = s_reg.scl_s1;

		// APB answers in the access cycle, zero wait
		s_next.ready = 1'b0;
		s_next.err   = 1'b0;
		if (psel && !penable) begin
			s_next.ready = 1'b1;
			s_next.rdata = 32'h0000_0000;
			case (paddr)
				ADDR_WORD_COUNT: s_next.rdata = {16'h0000,
					s_reg.word_count_field};
				ADDR_RECEIVE:    s_next.rdata = {24'h000000,
					s_reg.receive_buffer};
				ADDR_TARGET:     s_next.rdata = {22'h000000,
					s_reg.target_address_field};
				ADDR_TRANSMIT:   s_next.rdata = {24'h000000,
					s_reg.transmit_buffer};
				ADDR_MODE:       s_next.rdata = {16'h0000, s_reg.mode};
				ADDR_STATUS:     s_next.rdata = {15'h0000, s_reg.counter};
				default:         s_next.err = 1'b1; // Unmapped
			endcase
		end

		// Register writes take effect at the ready edge
		if (wr && s_reg.ready) begin
			case (paddr)
				ADDR_WORD_COUNT: s_next.word_count_field = pwdata[15:0];
				ADDR_TARGET: s_next.target_address_field = pwdata[9:0];
				ADDR_TRANSMIT: begin
					s_next.transmit_buffer = pwdata[7:0];
					s_next.tx_full         = 1'b1;
				end
				ADDR_MODE: s_next.mode = wmode;
				default: ;
			endcase
		end
		// Reading the receive buffer frees it
		if (rd && s_reg.ready && paddr == ADDR_RECEIVE) begin
			s_next.rx_full = 1'b0;
		end

		// Bit timing: eight ticks per bit, clock low on ticks 0-3
		// Data moves on tick 1, mid low, so it never races a clock edge
		if (!s_reg.mode[MODE_RUN]) begin
			s_next.phase = ST_IDLE;
			s_next.pins  = '0;
			s_next.tick  = 3'h0;
		end else begin
			s_next.tick = (s_reg.phase == ST_IDLE) ? 3'h0 : s_reg.tick + 3'h1;
			case (s_reg.phase)
				ST_IDLE: begin
					s_next.pins = '0;
					if (s_reg.mode[MODE_START] && s_reg.mode[MODE_MASTER]) begin
						s_next.phase   = ST_START;
						s_next.restart = 1'b0;
						s_next.counter = count_start(s_reg.word_count_field);
					end
				end
				ST_START: begin
					// Clock dips only for a repeated start; data falls
					// late while the clock is high: start condition
					s_next.pins.scl_oe = clk_low && s_reg.restart;
					if (s_reg.tick != 3'h0) begin
						s_next.pins.sda_oe = (s_reg.tick >= TICK_FALL);
					end
					if (step_end) begin
						s_next.mode[MODE_START] = 1'b0;
						if (s_reg.mode[MODE_FREE_FORMAT]) begin
							s_next.phase = ST_DATA;
							s_next.bits  = len;
							sh_load      = 1'b1;
							s_next.tx_full = 1'b0;
						end else begin
							s_next.phase = ST_ADDR;
							// Zero address goes out as general call
							if (s_reg.mode[MODE_WIDE_ADDR]) begin
								s_next.addr_sr = {s_reg.target_address_field,
									!s_reg.mode[MODE_TRANSMITTER]};
							end else begin
								s_next.addr_sr = {3'b000,
									7'(s_reg.target_address_field & NARROW_ADDR_MASK),
									!s_reg.mode[MODE_TRANSMITTER]};
							end
							s_next.bits = s_reg.mode[MODE_WIDE_ADDR] ? 4'hB : 4'h8;
						end
					end
				end
				ST_ADDR: begin
					s_next.pins.scl_oe = clk_low;
					if (s_reg.tick != 3'h0) begin
						s_next.pins.sda_oe = !s_reg.addr_sr[s_reg.mode[MODE_WIDE_ADDR]
							? 10 : 7];
					end
					if (step_end) begin
						s_next.addr_sr = {s_reg.addr_sr[9:0], 1'b0};
						s_next.bits    = s_reg.bits - 4'h1;
						if (s_reg.bits == 4'h1) begin
							// Slave answers the address in its own slot
							s_next.phase      = ST_ACK;
							s_next.first_addr = 1'b1;
						end
					end
				end
				ST_DATA: begin
					s_next.pins.scl_oe = clk_low;
					if (s_reg.tick != 3'h0) begin
						s_next.pins.sda_oe = s_reg.mode[MODE_TRANSMITTER] && !tx_bit;
					end
					if (step_end) begin
						// Synchronised data sampled late in the high half
						sh_shift    = 1'b1;
						s_next.bits = s_reg.bits - 4'h1;
						if (s_reg.bits == 4'h1) begin
							s_next.phase   = ST_ACK;
							s_next.counter = s_reg.counter - 17'h00001;
						end
					end
				end
				ST_ACK: begin
					s_next.pins.scl_oe = clk_low;
					// Receiver acks unless counter done or nack forced
					if (s_reg.tick != 3'h0) begin
						s_next.pins.sda_oe = !s_reg.first_addr
							&& !s_reg.mode[MODE_TRANSMITTER]
							&& s_reg.counter != 17'h00000
							&& !s_reg.mode[MODE_FORCE_NO_ACK];
					end
					if (step_end) begin
						s_next.first_addr = 1'b0;
						if (s_reg.first_addr) begin
							s_next.phase = ST_DATA;
							s_next.bits  = len;
							sh_load      = s_reg.mode[MODE_TRANSMITTER];
							s_next.tx_full = 1'b0;
						end else begin
							if (!s_reg.mode[MODE_TRANSMITTER]) begin
								// Word lands right aligned in the buffer
								s_next.receive_buffer = rx_word;
								s_next.rx_full        = 1'b1;
								s_next.mode[MODE_FORCE_NO_ACK] = 1'b0;
							end
							if (s_reg.mode[MODE_STOP] && s_reg.counter == 17'h00000
								&& (counting || !s_reg.mode[MODE_TRANSMITTER])) begin
								s_next.phase = ST_STOP;
							end else if (s_reg.mode[MODE_START]) begin
								s_next.phase   = ST_START;
								s_next.restart = 1'b1;
								s_next.counter = count_start(s_reg.word_count_field);
							end else begin
								s_next.phase = ST_DATA;
								s_next.bits  = len;
								sh_load      = s_reg.mode[MODE_TRANSMITTER];
								s_next.tx_full = 1'b0;
							end
						end
					end
				end
				ST_STOP: begin
					// Data low under a low clock, clock released, then
					// data let go from idle while the clock is high
					s_next.pins.scl_oe = clk_low;
					if (s_reg.tick != 3'h0) begin
						s_next.pins.sda_oe = 1'b1;
					end
					if (step_end) begin
						s_next.phase = ST_IDLE;
						s_next.mode[MODE_STOP]   = 1'b0;
						s_next.mode[MODE_MASTER] = 1'b0;
					end
				end
				default: s_next.phase = ST_IDLE;
			endcase
			s_next.pins.scl_o = 1'b0;
			s_next.pins.sda_o = 1'b0;
		end
		// A stop or master clear from hardware beats a same-cycle write,
		// as it is applied after the write; software rewrite then re-arms.
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata  = s_reg.rdata;
	assign pready  = s_reg.ready;
	assign pslverr = s_reg.err;
	assign scl_o   = s_reg.pins.scl_o;
	assign scl_oe  = s_reg.pins.scl_oe;
	assign sda_o   = s_reg.pins.sda_o;
	assign sda_oe  = s_reg.pins.sda_oe;

	// Software count never moves under the counter
	a_count_static: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && s_reg.ready && paddr == ADDR_WORD_COUNT)
		|=> $stable(s_reg.word_count_field))
		else $error("count register moved");
	// Upper count bits read zero
	a_count_upper: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && paddr == ADDR_WORD_COUNT) |-> prdata[31:16] == 16'h0000)
		else $error("count upper bits not zero");
	// Zero count loads full range
	a_count_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(s_reg.phase == ST_IDLE && s_next.phase == ST_START
			&& s_reg.word_count_field == 16'h0000)
		|=> s_reg.counter == COUNT_FULL)
		else $error("zero count not 65536");
	// Stop clears both bits
	a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn)
		(s_reg.phase == ST_STOP && s_reg.tick == TICK_LAST
			&& s_reg.mode[MODE_RUN])
		|=> !s_reg.mode[MODE_STOP] && !s_reg.mode[MODE_MASTER])
		else $error("stop did not clear bits");
	// Address upper bits read zero
	a_addr_upper: assert property (@(posedge pclk) disable iff (!presetn)
		(pready && paddr == ADDR_TARGET) |-> prdata[31:10] == 22'h000000)
		else $error("address upper bits not zero");
	// Received word copied on ack
	a_rx_copy: assert property (@(posedge pclk) disable iff (!presetn)
		(s_reg.phase == ST_ACK && s_reg.tick == TICK_LAST
			&& s_reg.mode[MODE_RUN] && !s_reg.first_addr
			&& !s_reg.mode[MODE_TRANSMITTER])
		|=> s_reg.receive_buffer == $past(rx_word))
		else $error("receive buffer not copied");
	// Reserved mode bit reads zero
	a_mode_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
		s_reg.mode[12] == 1'b0)
		else $error("reserved mode bit set");
	// Counter steps by one per word
	a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
		(s_reg.phase == ST_DATA && s_next.phase == ST_ACK)
		|=> s_reg.counter == $past(s_reg.counter) - 17'h00001)
		else $error("counter step wrong");
endmodule // twi_data_path
`default_nettype wire

// >>> testbench/twi_slave_model.sv
// Bus slave model: acks address and written words, returns one read byte
`timescale 1ns/10ps
`default_nettype none
module twi_slave_model (
	input  wire logic       scl,     // Clock wire level
	input  wire logic       sda,     // Data wire level
	input  wire logic [7:0] rd_byte, // Byte returned on a read
	output logic            pull,    // High while pulling data low
	output int              edges,   // Rising clock edges in this frame
	output int              stops,   // Stop conditions seen
	output logic [0:26]     cap      // Bits seen at rising clock edges
);
	int k; // Bit slot within a byte, 8 is the ack slot
	int b; // Byte slot within the frame

	// Quiet line at time zero
	initial begin
		pull = 1'b0;
		edges = 0;
		stops = 0;
		cap = '0;
	end

	// Start: data falls while clock high, new frame
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			edges = 0;
			pull = 1'b0;
		end
	end

	// Stop: data rises while clock high, line let go
	always @(posedge sda) begin
		if (scl === 1'b1) begin
			stops = stops + 1;
			pull = 1'b0;
		end
	end

	// Record each bit as the clock rises
	always @(posedge scl) begin
		if (edges < 27)
			cap[edges] = sda;
		edges = edges + 1;
	end

	// Data changes only while the clock is low; released line floats high
	always @(negedge scl) begin
		k = edges % 9;
		b = edges / 9;
		if (k == 8 && (b == 0 || !cap[7]))
			pull = 1'b1;
		else if (b == 1 && cap[7] && k < 8)
			pull = !rd_byte[7 - k];
		else
			pull = 1'b0;
	end
endmodule // twi_slave_model
`default_nettype wire

// >>> testbench/tb_twi_data_path.sv
// Testbench for the two-wire count, address and data path
`timescale 1ns/10ps
`default_nettype none
module tb_twi_data_path;
	import twi_path_pkg::*;
	logic        pclk;       // Module clock
	logic        presetn;    // Reset, low
	logic        psel;       // APB select
	logic        penable;    // APB access phase
	logic        pwrite;     // APB direction
	logic [7:0]  paddr;      // APB address
	logic [31:0] pwdata;     // APB write data
	logic [31:0] prdata;     // APB read data
	logic        pready;     // APB ready
	logic        pslverr;    // APB error
	logic        scl_oe;     // Design pulls clock low
	logic        sda_oe;     // Design pulls data low
	logic        scl_w;      // Clock wire with pull-up
	logic        sda_w;      // Data wire with pull-up
	logic        pull;       // Partner pulls data low
	logic [7:0]  rd_byte;    // Byte the partner returns
	int          edges;      // Clock rises in last frame
	int          stops;      // Stops seen
	logic [0:26] cap;        // Bits seen on the wire
	int          err_total;  // Mismatches
	int          num_checks; // Comparisons
	logic [31:0] mdl [0:6];  // Register image of the model

	// Open drain wires: any driver low wins
	assign scl_w = !scl_oe;
	assign sda_w = !(sda_oe || pull);

	twi_data_path u_twi_data_path (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_i(scl_w), .sda_i(sda_w),
		.scl_o(), .scl_oe(scl_oe), .sda_o(), .sda_oe(sda_oe)
	);
	twi_slave_model u_twi_slave_model (
		.scl(scl_w), .sda(sda_w), .rd_byte(rd_byte), .pull(pull),
		.edges(edges), .stops(stops), .cap(cap)
	);

	// Clock
	initial pclk = 1'b0;
	always #50 pclk = !pclk;

	// Verdict and end of run
	task automatic wrap_up();
		if (err_total == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Writable bits of each register; read-only places have none
	function automatic logic [31:0] mask(input logic [7:0] a);
		case (a)
			ADDR_WORD_COUNT: return 32'h0000FFFF;
			ADDR_TARGET:     return 32'h000003FF;
			ADDR_TRANSMIT:   return 32'h000000FF;
			ADDR_MODE:       return 32'h0000EFFF;
			default:         return 32'h00000000;
		endcase
	endfunction

	// One APB transfer, request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		check({31'h0, pready}, 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write and update the model; only the unmapped place errs
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
		check({31'h0, e}, {31'h0, a == 8'h18});
		mdl[a >> 2] = (mdl[a >> 2] & ~mask(a)) | (d & mask(a));
	endtask

	// Read and compare with the model
	task automatic rd_chk(input logic [7:0] a);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, mdl[a >> 2]);
		check({31'h0, e}, {31'h0, a == 8'h18});
	endtask

	// One single-word master transfer, then a full register sweep
	task automatic xfer(input logic [9:0] ta, input logic rx);
		logic [7:0] txb;
		int         s0;
		int         n;
		txb = 8'($urandom);
		rd_byte <= 8'($urandom);
		wr(ADDR_WORD_COUNT, 32'hFFFF0001);
		wr(ADDR_TARGET, {22'h3FFFFF, ta});
		wr(ADDR_TRANSMIT, {24'hFFFFFF, txb});
		s0 = stops;
		n = 0;
		wr(ADDR_MODE, rx ? 32'h00002C20 : 32'h00002E20);
		while (stops == s0 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		check({31'h0, n < 3000}, 32'h1);
		repeat (4) @(posedge pclk);
		// Start drops after the start phase, stop and master once the stop is sent
		mdl[4] = mdl[4] & 32'hFFFFD3FF;
		check(32'(edges), 32'd19);
		check(32'(cap[0:6]), 32'(ta[6:0]));
		check({31'h0, cap[7]}, {31'h0, rx});
		check({31'h0, cap[8]}, 32'h0);
		check(32'(cap[9:16]), rx ? 32'(rd_byte) : 32'(txb));
		if (rx) begin
			check({31'h0, cap[17]}, 32'h1);
			mdl[1] = 32'(rd_byte);
		end
		for (int a = 0; a < 28; a += 4) rd_chk(8'(a));
	endtask

	// Main sequence
	initial begin
		logic [31:0] seed_val;
		logic [31:0] rv;
		logic        ev;
		seed_val = $urandom(2);
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rd_byte = 8'h00;
		err_total = 0;
		num_checks = 0;
		for (int i = 0; i < 7; i++) mdl[i] = 32'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int a = 0; a < 28; a += 4) rd_chk(8'(a));
		// Master and start kept low so no frame begins
		for (int a = 0; a < 28; a += 4) wr(8'(a), 32'hFFFFDBFF);
		for (int a = 0; a < 28; a += 4) rd_chk(8'(a));
		wr(ADDR_MODE, 32'h0);
		xfer(10'($urandom), 1'b0);
		xfer(10'h380, 1'b0);
		xfer(10'($urandom), 1'b1);
		// Zero count loads the full range, then a reset in mid-frame
		wr(ADDR_WORD_COUNT, 32'h0);
		wr(ADDR_MODE, 32'h00002620);
		apb(1'b0, ADDR_STATUS, 32'h0, rv, ev);
		check(rv, 32'h00010000);
		repeat (30) @(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) mdl[i] = 32'h0;
		for (int a = 0; a < 28; a += 4) rd_chk(8'(a));
		wrap_up();
	end

	// Watchdog: whole run needs well under 2000 clocks
	initial begin
		#1000000;
		err_total++;
		wrap_up();
	end
endmodule // tb_twi_data_path
`default_nettype wire
